// ---- hw/tsw_pkg.sv ----
// constants for the tape unit select and write path block
// assumes a 200 MHz pclk and a 32-bit APB register bus
package tsw_pkg;

  // ****************************
  // timing
  // ****************************
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int HI_DENS_HZ = 60_000;
  localparam int MID_DENS_HZ = 41_700;
  localparam int PULSE_NS = 400;
  // period counts, rounded down so the rate never falls short
  localparam int HI_PERIOD_CYC = CLK_HZ / HI_DENS_HZ;
  localparam int MID_PERIOD_CYC = CLK_HZ / MID_DENS_HZ;
  // pulse width, rounded up, at least one cycle
  localparam int PULSE_CYC_RAW = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;

  // ****************************
  // channels and delays
  // ****************************
  localparam int NUM_CH_DEF = 7;
  localparam int DLY_W_DEF = 8;
  localparam int MAX_CH = 16;

  // ****************************
  // register map (byte addresses)
  // ****************************
  localparam logic [11:0] CFG_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] DLY_BASE_OFS = 12'h010;
  localparam int CFG_UNIT_LSB = 0;
  localparam int CFG_AUTO_BIT = 4;
  localparam logic [4:0] CFG_RST = 5'h00;
  localparam int ST_ONLINE_BIT = 0;
  localparam int ST_WE_BIT = 1;
  localparam int ST_FWD_BIT = 2;
  localparam int ST_MATCH_BIT = 3;
  localparam int ST_DENS_LSB = 4;
  localparam int ST_WBUF_LSB = 8;
  localparam logic [7:0] DLY_RST = 8'h10;

  // ****************************
  // APB answer
  // ****************************
  typedef enum logic [0:0] {
    TSW_IDLE = 1'b0,
    TSW_ACK = 1'b1
  } tsw_apb_t;

endpackage

// ---- hw/tsw_top.sv ----
// tape unit select, density clocks, write enabling, forward motion,
// start delay signalling and per-channel NRZ write recording
// assumes controller pins are asynchronous to pclk; APB master on pclk
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps

// What this block does
// - addressed only when address equals selector switch
// - decode address one-hot, switch picks unit_matched
// - selected_online needs unit_matched and automatic mode
// - two free-running density clocks, 400 ns pulses
// - density clocks forwarded only while selected_online
// - one density line lights lamp
// - write enable needs auto, selected, ring present
// - set function plus write select sets enable
// - write drivers enabled only by write enable
// - forward set unless reversing or rewinding
// - forward flip-flop drives pinch roller output
// - controller sends motion delay with forward command
// - motion delay and start drive line 2/6
// - start and stop delays split the gap
// - record pulse while online gives write strobe
// - ground level means one, negative level zero
// - strobed ones start channel delay, then toggle
// - each channel delay separately adjustable
// - buffer toggle records one, none records zero
// - master clear clears forward, enable, buffers
module tsw_top
  import tsw_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF,
  parameter int DLY_W = DLY_W_DEF,
  parameter int HI_PERIOD = HI_PERIOD_CYC,
  parameter int MID_PERIOD = MID_PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] unit_addr,
  input wire logic set_function_cmd,
  input wire logic write_select_n,
  input wire logic forward_cmd,
  input wire logic motion_delay_cmd,
  input wire logic start_cmd,
  input wire logic record_data_pulse,
  input wire logic density_low,
  input wire logic density_mid,
  input wire logic density_high,
  input wire logic ring_present,
  input wire logic reversing,
  input wire logic rewinding,
  input wire logic master_clear_pulse,
  input wire logic [NUM_CH-1:0] write_data_gnd,
  output logic selected_online,
  output logic clk_high_density,
  output logic clk_mid_density,
  output logic [2:0] density_lamp,
  output logic write_enable_ff,
  output logic forward_ff,
  output logic write_drive_en,
  output logic read_line_2_6,
  output logic [NUM_CH-1:0] head_current
);

  // ****************************
  // elaboration checks
  // ****************************
  if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
    $error("NUM_CH must be 1 to 16");
  end
  if (DLY_W < 1 || DLY_W > 16) begin : g_bad_dly
    $error("DLY_W must be 1 to 16");
  end
  if (HI_PERIOD <= PULSE_CYC || HI_PERIOD > 65535) begin : g_bad_hi
    $error("HI_PERIOD out of range");
  end
  if (MID_PERIOD <= PULSE_CYC || MID_PERIOD > 65535) begin : g_bad_mid
    $error("MID_PERIOD out of range");
  end

  localparam int IN_W = 16 + NUM_CH;
  localparam logic [15:0] HI_LAST = 16'(HI_PERIOD - 1);
  localparam logic [15:0] MID_LAST = 16'(MID_PERIOD - 1);
  localparam logic [15:0] PULSE_LEN = 16'(PULSE_CYC);

  // ****************************
  // input synchronisers
  // ****************************
  logic [IN_W-1:0] in_raw;
  logic [IN_W-1:0] sync1_reg;
  logic [IN_W-1:0] sync2_reg;
  logic [2:0] pulse_prev_reg;
  logic [2:0] addr_s;
  logic sfn_s;
  logic wsel_n_s;
  logic fwd_s;
  logic emd_s;
  logic start_s;
  logic rec_s;
  logic dlow_s;
  logic dmid_s;
  logic dhigh_s;
  logic ring_s;
  logic rev_s;
  logic rew_s;
  logic mclr_s;
  logic [NUM_CH-1:0] wdata_s;

  assign in_raw = {unit_addr, set_function_cmd, write_select_n,
                   forward_cmd, motion_delay_cmd, start_cmd,
                   record_data_pulse, density_low, density_mid,
                   density_high, ring_present, reversing, rewinding,
                   master_clear_pulse, write_data_gnd};

  // two flops on every pin; only the second is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= in_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign {addr_s, sfn_s, wsel_n_s, fwd_s, emd_s, start_s, rec_s,
          dlow_s, dmid_s, dhigh_s, ring_s, rev_s, rew_s, mclr_s,
          wdata_s} = sync2_reg;

  // last synchronised level of each pulse line, for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_prev_reg <= '0;
    end else begin
      pulse_prev_reg <= {sfn_s, rec_s, mclr_s};
    end
  end

  logic sfn_edge;
  logic rec_edge;
  logic mclr_edge;

  // one action per external pulse, however long it lasts
  assign sfn_edge = sfn_s & ~pulse_prev_reg[2];
  assign rec_edge = rec_s & ~pulse_prev_reg[1];
  assign mclr_edge = mclr_s & ~pulse_prev_reg[0];

  // ****************************
  // registers seen by software
  // ****************************
  logic [2:0] unit_sel_reg;
  logic auto_mode_reg;
  logic [DLY_W-1:0] dly_reg [NUM_CH];
  logic wr_take;
  logic [11:0] dly_ofs [NUM_CH];

  // write lands at the edge the master sees pready
  assign wr_take = psel & penable & pready & pwrite;

  // selector switch and automatic mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_sel_reg <= CFG_RST[CFG_UNIT_LSB +: 3];
      auto_mode_reg <= CFG_RST[CFG_AUTO_BIT];
    end else if (wr_take && paddr == CFG_OFS) begin
      unit_sel_reg <= pwdata[CFG_UNIT_LSB +: 3];
      auto_mode_reg <= pwdata[CFG_AUTO_BIT];
    end
  end

  // per-channel write delays, one word each
  for (genvar c = 0; c < NUM_CH; c++) begin : g_dly
    assign dly_ofs[c] = DLY_BASE_OFS + 12'(4 * c);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dly_reg[c] <= DLY_W'(DLY_RST);
      end else if (wr_take && paddr == dly_ofs[c]) begin
        dly_reg[c] <= pwdata[DLY_W-1:0];
      end
    end
  end

  // ****************************
  // unit selection
  // ****************************
  logic [7:0] addr_onehot;
  logic unit_matched_reg;

  assign addr_onehot = 8'h01 << addr_s;

  // switch picks one decoder line, so only 0-7 can match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_matched_reg <= 1'b0;
    end else begin
      unit_matched_reg <= addr_onehot[unit_sel_reg];
    end
  end

  // online needs both the match and automatic mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selected_online <= 1'b0;
    end else begin
      selected_online <= unit_matched_reg & auto_mode_reg;
    end
  end

  // ****************************
  // density clocks
  // ****************************
  logic [15:0] hi_cnt_reg;
  logic [15:0] mid_cnt_reg;

  // both sources run free, whether online or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_reg <= '0;
      mid_cnt_reg <= '0;
    end else begin
      hi_cnt_reg <= (hi_cnt_reg == HI_LAST) ? '0 : hi_cnt_reg + 16'h0001;
      mid_cnt_reg <= (mid_cnt_reg == MID_LAST) ? '0 : mid_cnt_reg + 16'h0001;
    end
  end

  // pulses go out only while online; a pulse cut mid-way is short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_high_density <= 1'b0;
      clk_mid_density <= 1'b0;
    end else begin
      clk_high_density <= selected_online & (hi_cnt_reg < PULSE_LEN);
      clk_mid_density <= selected_online & (mid_cnt_reg < PULSE_LEN);
    end
  end

  // ****************************
  // density indicators
  // ****************************
  // the controller keeps exactly one line high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      density_lamp <= 3'h0;
    end else if (selected_online) begin
      density_lamp <= {dhigh_s, dmid_s, dlow_s};
    end else begin
      density_lamp <= 3'h0;
    end
  end

  // ****************************
  // write enable and forward motion
  // ****************************
  logic set_function_pulse;
  logic set_write_enable_pulse;
  logic set_forward_pulse;

  assign set_function_pulse = sfn_edge & selected_online;
  assign set_write_enable_pulse = set_function_pulse & ~wsel_n_s;
  assign set_forward_pulse = set_function_pulse & fwd_s;

  // a set in the same cycle as a master clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_enable_ff <= 1'b0;
    end else if (set_write_enable_pulse && ring_s) begin
      write_enable_ff <= 1'b1;
    end else if (mclr_edge) begin
      write_enable_ff <= 1'b0;
    end
  end

  // forward refused while reversing or rewinding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forward_ff <= 1'b0;
    end else if (set_forward_pulse && !rev_s && !rew_s) begin
      forward_ff <= 1'b1;
    end else if (mclr_edge) begin
      forward_ff <= 1'b0;
    end
  end

  // driver enable to the write amplifiers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_drive_en <= 1'b0;
    end else begin
      write_drive_en <= write_enable_ff;
    end
  end

  // ****************************
  // write start delay signalling
  // ****************************
  // the controller counts this down to time half the gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_line_2_6 <= 1'b0;
    end else begin
      read_line_2_6 <= emd_s & start_s;
    end
  end

  // ****************************
  // record strobe and channels
  // ****************************
  logic write_strobe;

  // strobe ignored when not online
  assign write_strobe = rec_edge & selected_online;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [DLY_W:0] dly_cnt_reg;
    logic fire;

    // count of dly_reg+1 cycles; zero means idle
    assign fire = (dly_cnt_reg == (DLY_W+1)'(1));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dly_cnt_reg <= '0;
      end else if (mclr_edge) begin
        dly_cnt_reg <= '0;
      end else if (write_strobe && wdata_s[c] && write_enable_ff) begin
        dly_cnt_reg <= {1'b0, dly_reg[c]} + (DLY_W+1)'(1);
      end else if (dly_cnt_reg != '0) begin
        dly_cnt_reg <= dly_cnt_reg - (DLY_W+1)'(1);
      end
    end

    // a toggle reverses head current: that is a one
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        head_current[c] <= 1'b0;
      end else if (mclr_edge) begin
        head_current[c] <= 1'b0;
      end else if (fire && write_enable_ff) begin
        head_current[c] <= ~head_current[c];
      end
    end
  end

  // ****************************
  // APB slave
  // ****************************
  tsw_apb_t apb_state_reg;
  logic [31:0] rd_next;
  logic hit_next;

  // read mux and address decode
  always_comb begin
    rd_next = 32'h0000_0000;
    hit_next = 1'b0;
    if (paddr == CFG_OFS) begin
      hit_next = 1'b1;
      rd_next[CFG_UNIT_LSB +: 3] = unit_sel_reg;
      rd_next[CFG_AUTO_BIT] = auto_mode_reg;
    end else if (paddr == STATUS_OFS) begin
      hit_next = 1'b1;
      rd_next[ST_ONLINE_BIT] = selected_online;
      rd_next[ST_WE_BIT] = write_enable_ff;
      rd_next[ST_FWD_BIT] = forward_ff;
      rd_next[ST_MATCH_BIT] = unit_matched_reg;
      rd_next[ST_DENS_LSB +: 3] = {dhigh_s, dmid_s, dlow_s};
      rd_next[ST_WBUF_LSB +: NUM_CH] = head_current;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (paddr == dly_ofs[i]) begin
        hit_next = 1'b1;
        rd_next[DLY_W-1:0] = dly_reg[i];
      end
    end
  end

  // one wait state: pready rises the cycle after access starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_reg <= TSW_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (apb_state_reg)
        TSW_IDLE: begin
          if (psel && penable) begin
            apb_state_reg <= TSW_ACK;
            pready <= 1'b1;
            pslverr <= ~hit_next;
            prdata <= (hit_next && !pwrite) ? rd_next : 32'h0000_0000;
          end
        end
        TSW_ACK: begin
          apb_state_reg <= TSW_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= 32'h0000_0000;
        end
        default: begin
          apb_state_reg <= TSW_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- testbench/tsw_props.sv ----
// checker for the tape select and write path ports
// assumes binding onto tsw_top, handing on its parameters
`timescale 1ns/1ps
module tsw_props
  import tsw_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF,
  parameter int HI_PERIOD = HI_PERIOD_CYC
) (
  input logic pclk,
  input logic presetn,
  input logic selected_online,
  input logic clk_high_density,
  input logic clk_mid_density,
  input logic [2:0] density_lamp,
  input logic write_enable_ff,
  input logic forward_ff,
  input logic write_drive_en,
  input logic read_line_2_6,
  input logic [NUM_CH-1:0] head_current,
  input logic motion_delay_cmd,
  input logic start_cmd,
  input logic master_clear_pulse,
  input logic set_function_cmd,
  input logic write_select_n,
  input logic forward_cmd,
  input logic ring_present,
  input logic reversing,
  input logic rewinding
);
  int hcnt;
  int hgap;
  logic hseen;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ******
  // helper counters
  // ******
  // hseen skips pulses cut short when selected_online rises or falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt <= 0;
      hgap <= 0;
      hseen <= 1'b0;
    end else begin
      hcnt <= clk_high_density ? hcnt + 1 : 0;
      hgap <= $rose(clk_high_density) ? 1 : hgap + 1;
      hseen <= selected_online && (hseen || ($rose(clk_high_density)
        && $past(selected_online, 3)));
    end
  end

  // ******
  // properties
  // ******
  sequence s_arm_we;
    (selected_online && !write_select_n && ring_present)[*6];
  endsequence
  sequence s_arm_fwd;
    (selected_online && forward_cmd && !reversing && !rewinding)[*6];
  endsequence
  sequence s_clear;
    $rose(master_clear_pulse) ##1 (!set_function_cmd)[*6];
  endsequence

  a_hi_width: assert property ($fell(clk_high_density) && hseen && selected_online
    |-> hcnt == PULSE_CYC) else $error("fast clock pulse width wrong");
  a_hi_period: assert property ($rose(clk_high_density) && hseen && selected_online
    |-> hgap == HI_PERIOD) else $error("fast clock period wrong");
  a_idle_offline: assert property ((!selected_online)[*3] |-> !clk_high_density
    && !clk_mid_density && density_lamp == 3'h0) else $error("outputs active offline");
  a_drive_follows: assert property (write_drive_en == $past(write_enable_ff))
    else $error("write drive does not follow enable");
  a_heads_locked: assert property ((!write_enable_ff)[*3] |-> head_current == '0)
    else $error("head current while writing locked");
  a_line_on: assert property ((motion_delay_cmd && start_cmd)[*4] |-> read_line_2_6)
    else $error("start value line not driven");
  a_line_off: assert property ((!motion_delay_cmd || !start_cmd)[*4] |-> !read_line_2_6)
    else $error("start value line driven idle");
  a_clear_all: assert property (s_clear |-> !write_enable_ff && !forward_ff
    && head_current == '0) else $error("master clear incomplete");
  a_we_set: assert property ($rose(set_function_cmd) ##0 s_arm_we |-> write_enable_ff)
    else $error("write enable not set");
  a_fwd_set: assert property ($rose(set_function_cmd) ##0 s_arm_fwd |-> forward_ff)
    else $error("forward not set");
  a_no_ring: assert property ((!ring_present)[*6] |-> !$rose(write_enable_ff))
    else $error("write enable without ring");
endmodule

bind tsw_top tsw_props #(.NUM_CH(NUM_CH), .HI_PERIOD(HI_PERIOD)) u_props (.*);

// ---- testbench/tsw_ctrl_model.sv ----
// tape controller model driving the transport bus pins
// assumes the bench calls its tasks; own clock unrelated to pclk
`timescale 1ns/1ps
module tsw_ctrl_model #(
  parameter int NUM_CH = 7
) (
  output logic [2:0] unit_addr,
  output logic set_function_cmd,
  output logic write_select_n,
  output logic forward_cmd,
  output logic motion_delay_cmd,
  output logic start_cmd,
  output logic record_data_pulse,
  output logic density_low,
  output logic density_mid,
  output logic density_high,
  output logic master_clear_pulse,
  output logic [NUM_CH-1:0] write_data_gnd,
  input logic clk_high_density,
  input logic clk_mid_density,
  input logic read_line_2_6
);
  logic lclk;
  // ******
  // clock and idle levels
  // ******
  // controller clock, 160 ns, phase unrelated to pclk
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #80 lclk = ~lclk;
  end
  initial begin
    {unit_addr, set_function_cmd, forward_cmd, motion_delay_cmd} = 6'h0;
    {start_cmd, record_data_pulse, master_clear_pulse} = 3'h0;
    {density_low, density_mid, density_high} = 3'h0;
    write_select_n = 1'b1;
    write_data_gnd = '0;
  end

  // one pulse, two controller clocks wide, on the chosen line
  task automatic fire(input int k);
    @(posedge lclk);
    set_function_cmd <= (k == 0);
    record_data_pulse <= (k == 1);
    master_clear_pulse <= (k == 2);
    repeat (2) @(posedge lclk);
    {set_function_cmd, record_data_pulse, master_clear_pulse} <= 3'h0;
  endtask
  task automatic sel(input logic [2:0] a);
    @(posedge lclk);
    unit_addr <= a;
  endtask
  // exactly one density line high
  task automatic dens(input int d);
    @(posedge lclk);
    {density_high, density_mid, density_low} <= 3'h1 << d;
  endtask
  // levels settle before the pulse; then the start count runs out
  // no limit of its own: the bench watchdog ends a hang
  task automatic begin_write();
    @(posedge lclk);
    {write_select_n, forward_cmd} <= 2'h1;
    {motion_delay_cmd, start_cmd} <= 2'h3;
    fire(0);
    while (read_line_2_6 !== 1'b1) begin
      @(posedge lclk);
    end
    repeat (16) @(posedge lclk);
  endtask
  // word paced on the density clock; data released to its inverse
  task automatic word(input logic [NUM_CH-1:0] w, input logic paced);
    if (paced && density_low) repeat (4) @(posedge clk_high_density);
    else if (paced && density_mid) @(posedge clk_mid_density);
    else if (paced) @(posedge clk_high_density);
    @(posedge lclk);
    write_data_gnd <= w;
    fire(1);
    write_data_gnd <= ~w;
  endtask
  task automatic end_write();
    @(posedge lclk);
    {write_select_n, forward_cmd, motion_delay_cmd, start_cmd} <= 4'h8;
    fire(2);
  endtask
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the tape select and write path
// assumes tsw_ctrl_model as controller and the bound checker
`timescale 1ns/1ps
module tb;
  import tsw_pkg::*;
  localparam int NCH = 7;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] unit_addr, density_lamp;
  logic set_function_cmd, write_select_n, forward_cmd, motion_delay_cmd, start_cmd;
  logic record_data_pulse, density_low, density_mid, density_high, master_clear_pulse;
  logic ring_present, reversing, rewinding, selected_online, clk_high_density;
  logic clk_mid_density, write_enable_ff, forward_ff, write_drive_en, read_line_2_6;
  logic [NCH-1:0] write_data_gnd, head_current, acc;
  // rows: auto, switch, bus address, expected online
  logic [7:0] rows [7] = '{8'hb7, 8'hb4, 8'h81, 8'hff, 8'h7e, 8'hd8, 8'hb7};
  logic [NCH-1:0] words [4] = '{7'h55, 7'h7f, 7'h00, 7'h41};
  int failures = 0;
  int samples_checked = 0;

  tsw_top #(.NUM_CH(NCH), .HI_PERIOD(100), .MID_PERIOD(120)) u_tsw_top (.*);
  tsw_ctrl_model #(.NUM_CH(NCH)) u_tsw_ctrl_model (.*);

  // ******
  // clock, tasks
  // ******
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // request held until the rising edge that samples pready high; answer taken there
  // values read at the edge are those before its updates land, as the slave sees them
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    failures++;
    $display("BAD watchdog expected end seen hang");
    report_and_stop();
  end

  // ******
  // tests
  // ******
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ring_present, reversing, rewinding} = 3'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, CFG_OFS, {27'h0, rows[i][7], 1'b0, rows[i][6:4]});
      u_tsw_ctrl_model.sel(rows[i][3:1]);
      wait_cyc(6);
      chk("online", {31'h0, rows[i][0]}, {31'h0, selected_online});
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("matched", {31'h0, rows[i][6:4] == rows[i][3:1]}, {31'h0, q[ST_MATCH_BIT]});
    end
    $display("unit select done");
    for (int d = 0; d < 3; d++) begin
      u_tsw_ctrl_model.dens(d);
      wait_cyc(6);
      chk("lamp", 32'h1 << d, {29'h0, density_lamp});
      u_tsw_ctrl_model.word(7'h00, 1'b1);
    end
    apb(1'b1, CFG_OFS, 32'h3);
    wait_cyc(4);
    // one look per cycle, longer than either clock period
    repeat (130) begin
      wait_cyc(1);
      chk("clocks off", 32'h0, {30'h0, clk_high_density, clk_mid_density});
    end
    apb(1'b1, CFG_OFS, 32'h13);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, STATUS_OFS, 32'hffffffff);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status ro", 32'h0, {31'h0, q[ST_WE_BIT]});
    $display("density and bus done");
    // no ring, then each motion lockout
    u_tsw_ctrl_model.begin_write();
    chk("no ring", 32'h3, {29'h0, write_enable_ff, forward_ff, read_line_2_6});
    u_tsw_ctrl_model.end_write();
    @(posedge pclk);
    ring_present <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      {reversing, rewinding} <= 2'h1 << k;
      u_tsw_ctrl_model.begin_write();
      chk("lockout", 32'h2, {30'h0, write_enable_ff, forward_ff});
      u_tsw_ctrl_model.end_write();
      wait_cyc(10);
      chk("cleared", 32'h0, {30'h0, write_enable_ff, forward_ff});
    end
    @(posedge pclk);
    {reversing, rewinding} <= 2'h0;
    $display("refusals done");
    for (int c = 0; c < NCH; c++) apb(1'b1, DLY_BASE_OFS + 12'(4 * c), 32'(3 * c));
    apb(1'b0, DLY_BASE_OFS + 12'h018, 32'h0);
    chk("delay rw", 32'h12, q);
    u_tsw_ctrl_model.begin_write();
    chk("armed", 32'h7, {29'h0, write_enable_ff, forward_ff, write_drive_en});
    acc = '0;
    foreach (words[i]) begin
      u_tsw_ctrl_model.word(words[i], 1'b1);
      acc = acc ^ words[i];
      wait_cyc(40);
      chk("heads", {25'h0, acc}, {25'h0, head_current});
    end
    apb(1'b1, CFG_OFS, 32'h3);
    u_tsw_ctrl_model.word(7'h7f, 1'b0);
    wait_cyc(40);
    chk("offline heads", {25'h0, acc}, {25'h0, head_current});
    apb(1'b1, CFG_OFS, 32'h13);
    u_tsw_ctrl_model.end_write();
    wait_cyc(10);
    chk("clear all", 32'h0, {23'h0, head_current, write_enable_ff, forward_ff});
    $display("recording done");
    // reset in mid write
    u_tsw_ctrl_model.begin_write();
    @(posedge pclk);
    presetn <= 1'b0;
    wait_cyc(2);
    chk("reset outs", 32'h0, {29'h0, selected_online, write_enable_ff, forward_ff});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_OFS, 32'h0);
    chk("cfg reset", {27'h0, CFG_RST}, q);
    apb(1'b0, DLY_BASE_OFS, 32'h0);
    chk("delay reset", {24'h0, DLY_RST}, q);
    $display("reset done");
    report_and_stop();
  end
endmodule
